// file: port_p_pkg.sv
// Package for the port P general-purpose block: register offsets, bit masks and reset values.
// Assumes a 32-bit APB register bus with one aligned word per register.
package port_p_pkg;

  localparam int unsigned PORT_W = 8;

  // Register byte offsets.
  localparam logic [7:0] OFS_OUTPUT_DATA   = 8'h00;
  localparam logic [7:0] OFS_INPUT_LEVELS  = 8'h04;
  localparam logic [7:0] OFS_DIRECTION     = 8'h08;
  localparam logic [7:0] OFS_REDUCED_DRIVE = 8'h0C;
  localparam logic [7:0] OFS_PULL_ENABLE   = 8'h10;
  localparam logic [7:0] OFS_POLARITY      = 8'h14;
  localparam logic [7:0] OFS_IRQ_ENABLE    = 8'h18;
  localparam logic [7:0] OFS_IRQ_FLAGS     = 8'h1C;

  // Implemented bits 7 and 5-0; bit 6 is absent.
  localparam logic [7:0] IMPL_MASK = 8'hBF;
  // Pins driven by a PWM channel.
  localparam logic [7:0] PWM_MASK  = 8'h3F;
  // Pin forced to input by emergency shutdown.
  localparam int unsigned SHUTDOWN_PIN = 5;

  localparam logic [7:0] RESET_BYTE = 8'h00;

  // Per-pin pad controls toward the pad ring.
  typedef struct packed {
    logic [7:0] out_en;
    logic [7:0] out_val;
    logic [7:0] reduced;
    logic [7:0] pull_en;
    logic [7:0] pull_down;
  } pad_ctrl_s;

endpackage : port_p_pkg

// file: port_p_gpio_pin_interrupt.sv
// Port P configuration, input sampling and edge interrupt logic behind an APB slave.
// Assumes pins are asynchronous to clk; PWM enables and data come from logic on clk.
// Bus, PWM and pad controls share clk; rst_b is synchronous and active low.
//
// What this block does
// - Pin-input register always reads synchronised pin level, whatever the direction.
// - Writes to the pin-input register are ignored and change nothing.
// - Direction bit 1 makes the pin an output, 0 an input.
// - Enabled PWM channel forces its pin to output, except pin 5 during shutdown; stored direction is kept.
// - Emergency shutdown makes pin 5 an input; stored direction is kept.
// - Reduced-drive bit 1 selects reduced strength, only while the pin is output.
// - Reduced drive applies whether GPIO or PWM drives the pin.
// - Pull-enable bit 1 enables the pull device, only while the pin is input.
// - Polarity 1 means pull-down and rising edge; 0 pull-up and falling edge.
// - An edge matching the polarity sets that pin's interrupt flag.
// - Writing 1 to a flag clears it; flags written 0 stay.
// - Interrupt request is high while any flag and its enable are both set.
// - Cleared enable masks the flag from the request; the flag still sets.
// - Configuration and flag registers are readable and writable at any time.
// - Data register reads stored value where the direction bit is 1, pin level where it is 0.
// - An enabled PWM channel overrides the GPIO output value on its pin.
// - Edge detection works whether the pin is input or output.
`timescale 1ns/1ps
module port_p_gpio_pin_interrupt
  import port_p_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_b,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // PWM unit
  input  wire logic [7:0]  pwm_chan_en,
  input  wire logic [7:0]  pwm_out,
  input  wire logic        pwm_shutdown_en,
  // Pins
  input  wire logic [7:0]  pin_in,
  output pad_ctrl_s        pad_ctrl,
  // Interrupt
  output logic             irq
);

  logic [7:0] sync1_q;
  logic [7:0] sync2_q;
  logic [7:0] sample_q;
  logic [7:0] data_q;
  logic [7:0] dir_q;
  logic [7:0] rdrv_q;
  logic [7:0] pull_q;
  logic [7:0] pol_q;
  logic [7:0] ien_q;
  logic [7:0] flag_q;
  logic [7:0] flag_d;
  logic [7:0] edge_hit;
  logic [7:0] out_en_d;
  logic [7:0] rd_d;
  logic       wr_acc;
  logic       rd_acc;
  logic       hit;

  // Bus write strobes, one per register except the input-level register.
  logic       wr_data;
  logic       wr_dir;
  logic       wr_rdrv;
  logic       wr_pull;
  logic       wr_pol;
  logic       wr_ien;
  logic       wr_flag;

  // Pin edge and read helpers.
  logic [7:0] rise;
  logic [7:0] fall;
  logic [7:0] data_rd;

  // Pad control next values and their flip-flops.
  logic [7:0] pwm_own;
  logic [7:0] out_val_d;
  logic [7:0] reduced_d;
  logic [7:0] pull_en_d;
  logic [7:0] pull_dn_d;
  logic [7:0] out_en_q;
  logic [7:0] out_val_q;
  logic [7:0] reduced_q;
  logic [7:0] pull_en_q;
  logic [7:0] pull_dn_q;

  // A write lands only at the edge where the master sees pready high, so a
  // write-one clear cannot be applied twice and swallow an edge in between.
  assign wr_acc = psel && penable && pwrite && pready;
  assign rd_acc = psel && penable && !pwrite;

  // One strobe per register; the input-level offset has none, so writes there store nothing.
  assign wr_data = wr_acc && (paddr == OFS_OUTPUT_DATA);
  assign wr_dir  = wr_acc && (paddr == OFS_DIRECTION);
  assign wr_rdrv = wr_acc && (paddr == OFS_REDUCED_DRIVE);
  assign wr_pull = wr_acc && (paddr == OFS_PULL_ENABLE);
  assign wr_pol  = wr_acc && (paddr == OFS_POLARITY);
  assign wr_ien  = wr_acc && (paddr == OFS_IRQ_ENABLE);
  assign wr_flag = wr_acc && (paddr == OFS_IRQ_FLAGS);

  // The first stage feeds only the second stage.
  // Pins are asynchronous to clk, so two stages guard against metastability.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      sync1_q <= RESET_BYTE;
      sync2_q <= RESET_BYTE;
    end else begin
      sync1_q <= pin_in;
      sync2_q <= sync1_q;
    end
  end

  // The previous synchronised sample, kept only for edge detection.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      sample_q <= RESET_BYTE;
    end else begin
      sample_q <= sync2_q;
    end
  end

  // Edge detection ignores direction so a driven pin still flags its own transitions.
  // Bit 6 has no pin behind it, so it never produces an edge.
  genvar i;
  generate
    for (i = 0; i < PORT_W; i++) begin : g_edge
      assign rise[i]     = sync2_q[i] && !sample_q[i];
      assign fall[i]     = !sync2_q[i] && sample_q[i];
      assign edge_hit[i] = IMPL_MASK[i] && (pol_q[i] ? rise[i] : fall[i]);
    end
  endgenerate

  // Stored output value; it reaches the pad only while no PWM channel owns the pin.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      data_q <= RESET_BYTE;
    end else if (wr_data) begin
      data_q <= pwdata[7:0] & IMPL_MASK;
    end
  end

  // Stored direction; PWM and shutdown override the pad, never this register.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      dir_q <= RESET_BYTE;
    end else if (wr_dir) begin
      dir_q <= pwdata[7:0] & IMPL_MASK;
    end
  end

  // Reduced-drive selection.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      rdrv_q <= RESET_BYTE;
    end else if (wr_rdrv) begin
      rdrv_q <= pwdata[7:0] & IMPL_MASK;
    end
  end

  // Pull-device enable.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      pull_q <= RESET_BYTE;
    end else if (wr_pull) begin
      pull_q <= pwdata[7:0] & IMPL_MASK;
    end
  end

  // Pull and edge polarity share one bit per pin.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      pol_q <= RESET_BYTE;
    end else if (wr_pol) begin
      pol_q <= pwdata[7:0] & IMPL_MASK;
    end
  end

  // Interrupt enable; clearing a bit masks only the request, not the flag.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ien_q <= RESET_BYTE;
    end else if (wr_ien) begin
      ien_q <= pwdata[7:0] & IMPL_MASK;
    end
  end

  // A new edge wins over a simultaneous write-one clear.
  always_comb begin
    flag_d = flag_q;
    if (wr_flag) begin
      flag_d = flag_q & ~pwdata[7:0];
    end
    flag_d = (flag_d | edge_hit) & IMPL_MASK;
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      flag_q <= RESET_BYTE;
    end else begin
      flag_q <= flag_d;
    end
  end

  // The request follows the next flag value so irq tracks flag_q in the same cycle.
  // A changed enable shows on irq one cycle after the write lands.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      irq <= 1'b0;
    end else begin
      irq <= |(flag_d & ien_q);
    end
  end

  // Effective direction: PWM forces output, shutdown then forces pin 5 to input.
  assign pwm_own = pwm_chan_en & PWM_MASK;

  // Shutdown is applied last so it wins over a PWM channel on pin 5.
  always_comb begin
    out_en_d = dir_q | pwm_own;
    if (pwm_shutdown_en) begin
      out_en_d[SHUTDOWN_PIN] = 1'b0;
    end
    out_en_d = out_en_d & IMPL_MASK;
  end

  // Per pin: a live PWM channel owns the value, reduced drive follows whoever drives,
  // and the pull device only acts while the pin is an input.
  generate
    for (i = 0; i < PORT_W; i++) begin : g_pad
      assign out_val_d[i] = IMPL_MASK[i] && (pwm_own[i] ? pwm_out[i] : data_q[i]);
      assign reduced_d[i] = rdrv_q[i] && out_en_d[i];
      assign pull_en_d[i] = pull_q[i] && !out_en_d[i];
      assign pull_dn_d[i] = pol_q[i] && pull_q[i] && !out_en_d[i];
    end
  endgenerate

  // Pad controls are registered one field at a time, a cycle after their cause.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      out_en_q <= RESET_BYTE;
    end else begin
      out_en_q <= out_en_d;
    end
  end

  // Output value: the PWM level wins while its channel is enabled.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      out_val_q <= RESET_BYTE;
    end else begin
      out_val_q <= out_val_d;
    end
  end

  // Reduced drive stays set whichever function drives the pin.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      reduced_q <= RESET_BYTE;
    end else begin
      reduced_q <= reduced_d;
    end
  end

  // Pull enable: zero on every pin that is currently driven.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      pull_en_q <= RESET_BYTE;
    end else begin
      pull_en_q <= pull_en_d;
    end
  end

  // Pull direction: set for pull-down, meaningful only with the pull enabled.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      pull_dn_q <= RESET_BYTE;
    end else begin
      pull_dn_q <= pull_dn_d;
    end
  end

  // The pad bundle is built from flip-flops only.
  assign pad_ctrl = {out_en_q, out_val_q, reduced_q, pull_en_q, pull_dn_q};

  // A data read shows the stored bit where dir_q is 1 and the synchronised pin where it is 0.
  generate
    for (i = 0; i < PORT_W; i++) begin : g_data_rd
      assign data_rd[i] = dir_q[i] ? data_q[i] : sync2_q[i];
    end
  endgenerate

  // Read multiplexer.
  always_comb begin
    rd_d = 8'h00;
    hit  = 1'b1;
    case (paddr)
      OFS_OUTPUT_DATA:   rd_d = data_rd;
      OFS_INPUT_LEVELS:  rd_d = sync2_q;
      OFS_DIRECTION:     rd_d = dir_q;
      OFS_REDUCED_DRIVE: rd_d = rdrv_q;
      OFS_PULL_ENABLE:   rd_d = pull_q;
      OFS_POLARITY:      rd_d = pol_q;
      OFS_IRQ_ENABLE:    rd_d = ien_q;
      OFS_IRQ_FLAGS:     rd_d = flag_q;
      default:           hit  = 1'b0;
    endcase
    rd_d = rd_d & IMPL_MASK;
  end

  // Ready is registered, so each access takes one wait state and ready pulses once.
  // The master must therefore wait for pready rather than assume a count.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      pready <= 1'b0;
    end else begin
      pready <= psel && penable && !pready;
    end
  end

  // An unmapped offset answers with an error together with ready.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      pslverr <= 1'b0;
    end else begin
      pslverr <= psel && penable && !pready && !hit;
    end
  end

  // Read data stands only in the ready cycle of a read and is zero otherwise.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      prdata <= 32'h0000_0000;
    end else begin
      prdata <= (rd_acc && !pready) ? {24'h00_0000, rd_d} : 32'h0000_0000;
    end
  end

endmodule : port_p_gpio_pin_interrupt

// file: port_p_checker_sva.sv
// Checker for the port P block: bus handshake, pad gating and PWM overrides.
// Bound to the design top and sees only its ports.
`timescale 1ns/1ps
module port_p_checker
  import port_p_pkg::*;
(
  // Clock and reset
  input wire logic        clk,
  input wire logic        rst_b,
  // Bus and interrupt
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        irq,
  // PWM and pads
  input wire logic [7:0]  pwm_chan_en,
  input wire logic [7:0]  pwm_out,
  input wire logic        pwm_shutdown_en,
  input pad_ctrl_s        pad_ctrl
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  property p_ans; psel && penable && !pready |=> pready; endproperty
  property p_pulse; pready |=> !pready; endproperty
  property p_err; pslverr |-> pready; endproperty
  property p_wide; prdata[31:8] == 24'h000000 && !prdata[6]; endproperty
  property p_pull; (pad_ctrl.pull_en & pad_ctrl.out_en) == 8'h00; endproperty
  property p_red; (pad_ctrl.reduced & ~pad_ctrl.out_en) == 8'h00; endproperty
  property p_pwm; pwm_chan_en[4:0] != 5'h00 |=>
    (pad_ctrl.out_en[4:0] & $past(pwm_chan_en[4:0])) == $past(pwm_chan_en[4:0]); endproperty
  property p_pwmv; pwm_chan_en[4:0] != 5'h00 |=>
    ((pad_ctrl.out_val[4:0] ^ $past(pwm_out[4:0])) & $past(pwm_chan_en[4:0])) == 5'h00;
  endproperty
  property p_shut; pwm_shutdown_en |=> !pad_ctrl.out_en[5]; endproperty
  a_ans: assert property (p_ans) else $error("access not answered");
  a_pulse: assert property (p_pulse) else $error("ready too long");
  a_err: assert property (p_err) else $error("error without ready");
  a_wide: assert property (p_wide) else $error("absent read bit set");
  a_pull: assert property (p_pull) else $error("pull on output");
  a_red: assert property (p_red) else $error("reduced on input");
  a_pwm: assert property (p_pwm) else $error("channel not output");
  a_pwmv: assert property (p_pwmv) else $error("channel value lost");
  a_shut: assert property (p_shut) else $error("shutdown pin driven");
  c_rd: cover property (pready && !pslverr);
  c_err: cover property (pslverr);
  c_irq: cover property ($rose(irq));
endmodule : port_p_checker

// file: pin_model.sv
// Pin model: pads, outside drivers and pull devices on the port.
// Assumes pad controls on clk; undriven pins without pull wander.
`timescale 1ns/1ps
module pin_model
  import port_p_pkg::*;
(
  // Clock and pads
  input wire logic       clk,
  input pad_ctrl_s       pad,
  // Outside drivers
  input wire logic [7:0] ext_en,
  input wire logic [7:0] ext_val,
  output logic     [7:0] pins
);
  logic [7:0] wander_q = 8'h00;
  always_ff @(posedge clk) wander_q <= ~wander_q;
  // A floating pin never settles, so it cannot pass for a driven level.
  always_comb for (int i = 0; i < 8; i++) pins[i] = pad.out_en[i] ? pad.out_val[i] :
    ext_en[i] ? ext_val[i] : pad.pull_en[i] ? ~pad.pull_down[i] : wander_q[i];
endmodule : pin_model

// file: port_p_gpio_pin_interrupt_bench.sv
// Bench for the port P block: registers, pin reads, PWM overrides, edge interrupts.
// Assumes the pin model on the pads and the checker bound below.
`timescale 1ns/1ps
module port_p_gpio_pin_interrupt_bench;
  import port_p_pkg::*;
  logic clk = 1'h0, rst_b = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic [7:0] paddr = 8'h00, pwm_chan_en = 8'h00, pwm_out = 8'h00, pin_in;
  logic [7:0] ext_en = 8'hFF, ext_val = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, irq, er, pwm_shutdown_en = 1'h0;
  pad_ctrl_s pad_ctrl;
  int errors = 0, cmp_count = 0, cyc = 0;
  always #20 clk = ~clk;
  port_p_gpio_pin_interrupt u_dut (.clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pwm_chan_en(pwm_chan_en), .pwm_out(pwm_out),
    .pwm_shutdown_en(pwm_shutdown_en), .pin_in(pin_in), .pad_ctrl(pad_ctrl), .irq(irq));
  pin_model u_pins (.clk(clk), .pad(pad_ctrl), .ext_en(ext_en), .ext_val(ext_val),
    .pins(pin_in));
  task automatic wrap_up();
    $display("Comparisons %0d, mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : wrap_up
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'h1;
    do @(posedge clk); while (pready !== 1'h1);
    rd = prdata;
    er = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge clk);
  endtask : apb
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    apb(1'h0, a, 32'h0);
    chk(rd, e);
  endtask : rdchk
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      errors++;
      wrap_up();
    end
  end
  initial begin
    logic [31:0] v;
    logic [7:0] x;
    logic [7:0] pl;
    logic [7:0] po;
    void'($urandom(70334));
    repeat (10) @(posedge clk);
    rst_b <= 1'h1;
    @(posedge clk);
    for (int i = 0; i < 8; i++) rdchk(8'(i * 4), 32'h0);
    for (int i = 2; i < 7; i++) begin
      v = $urandom;
      if (i == 4) pl = v[7:0];
      if (i == 5) po = v[7:0];
      ext_en <= 8'($urandom);
      apb(1'h1, 8'(i * 4), v);
      rdchk(8'(i * 4), v & 32'(IMPL_MASK));
    end
    apb(1'h1, OFS_DIRECTION, 32'h0);
    apb(1'h1, OFS_REDUCED_DRIVE, 32'hFF);
    for (int i = 0; i < 30; i++) begin
      pwm_chan_en <= 8'($urandom);
      pwm_out <= 8'($urandom);
      pwm_shutdown_en <= 1'($urandom);
      @(posedge clk);
    end
    repeat (2) @(posedge clk);
    x = pwm_chan_en & PWM_MASK & ~(8'(pwm_shutdown_en) << 5);
    chk(32'(pad_ctrl.out_en), 32'(x));
    chk(32'(pad_ctrl.reduced), 32'(x));
    chk(32'(pad_ctrl.pull_en), 32'(pl & ~x & IMPL_MASK));
    chk(32'(pad_ctrl.pull_down), 32'(po & pl & ~x & IMPL_MASK));
    pwm_chan_en <= 8'h00;
    pwm_shutdown_en <= 1'h0;
    ext_en <= 8'hFF;
    x = 8'($urandom);
    ext_val <= x;
    apb(1'h1, OFS_INPUT_LEVELS, 32'(~x));
    rdchk(OFS_INPUT_LEVELS, 32'(x & IMPL_MASK));
    rdchk(OFS_OUTPUT_DATA, 32'(x & IMPL_MASK));
    v = $urandom;
    apb(1'h1, OFS_OUTPUT_DATA, v);
    apb(1'h1, OFS_DIRECTION, 32'hFF);
    // Pad register, pin and two synchroniser stages must settle before the read.
    repeat (3) @(posedge clk);
    rdchk(OFS_INPUT_LEVELS, v & 32'(IMPL_MASK));
    rdchk(OFS_OUTPUT_DATA, v & 32'(IMPL_MASK));
    apb(1'h1, OFS_DIRECTION, 32'h0);
    ext_val <= 8'h41;
    apb(1'h1, OFS_POLARITY, 32'h80);
    apb(1'h1, OFS_IRQ_ENABLE, 32'h01);
    apb(1'h1, OFS_IRQ_FLAGS, 32'hFF);
    ext_val <= 8'h80;
    repeat (4) @(posedge clk);
    chk(32'(irq), 32'h1);
    rdchk(OFS_IRQ_FLAGS, 32'h81);
    apb(1'h1, OFS_IRQ_ENABLE, 32'h00);
    @(posedge clk);
    chk(32'(irq), 32'h0);
    apb(1'h1, OFS_IRQ_FLAGS, 32'h01);
    rdchk(OFS_IRQ_FLAGS, 32'h80);
    apb(1'h1, OFS_IRQ_ENABLE, 32'h80);
    @(posedge clk);
    chk(32'(irq), 32'h1);
    apb(1'h1, 8'h20, 32'h0);
    chk(32'(er), 32'h1);
    wrap_up();
  end
endmodule : port_p_gpio_pin_interrupt_bench
bind port_p_gpio_pin_interrupt port_p_checker u_chk (.clk(clk), .rst_b(rst_b), .psel(psel),
  .penable(penable), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
  .pwm_chan_en(pwm_chan_en), .pwm_out(pwm_out), .pwm_shutdown_en(pwm_shutdown_en),
  .pad_ctrl(pad_ctrl));
